// *** hw/cdg_supply_edge_cfg.sv ***
`timescale 1ns/10ps
module cdg_supply_edge_cfg (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    input wire logic [cdg_pkg::SAMPLE_W-1:0] audio_in_data,
    input wire logic audio_in_valid,
    output logic audio_in_ready,
    output logic [cdg_pkg::SAMPLE_W-1:0] audio_out_data,
    output logic audio_out_valid,
    input wire logic audio_out_ready,
    input wire logic [7:0] vbat_dv,
    input wire logic peak_below_thresh,
    input wire logic [3:0] rail_switch_hold_time,
    output logic rail_battery_sel,
    output logic dg_active,
    output logic double_switch_freq,
    output logic ultrasound_only_enable,
    output logic fet_turnoff_slew_enable,
    output logic [3:0] battery_highside_slew
);
    import cdg_pkg::*;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [5:0] dg_sample_delay_r, dg_sample_delay_nxt;
    logic [1:0] amp_supply_mode_r, amp_supply_mode_nxt;
    logic [2:0] low_battery_force_level_r, low_battery_force_level_nxt;
    logic double_switch_freq_nxt, ultrasound_only_enable_nxt;
    logic fet_turnoff_slew_enable_nxt;
    logic [3:0] battery_highside_slew_nxt;
    logic [7:0] reg_rdata_nxt;
    logic reg_ack_nxt;

    // Register writes and read mux; unmapped reads return zero
    always_comb begin
        dg_sample_delay_nxt = dg_sample_delay_r;
        amp_supply_mode_nxt = amp_supply_mode_r;
        low_battery_force_level_nxt = low_battery_force_level_r;
        double_switch_freq_nxt = double_switch_freq;
        ultrasound_only_enable_nxt = ultrasound_only_enable;
        fet_turnoff_slew_enable_nxt = fet_turnoff_slew_enable;
        battery_highside_slew_nxt = battery_highside_slew;
        reg_rdata_nxt = reg_rdata;
        reg_ack_nxt = reg_wr || reg_rd;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_DG_SIGNAL_DELAY: dg_sample_delay_nxt = reg_wdata[DELAY_MSB:0];
                ADDR_AMP_OPERATING_MODE: amp_supply_mode_nxt = reg_wdata[MODE_MSB:0];
                ADDR_LOW_BATTERY_LEVEL: low_battery_force_level_nxt = reg_wdata[LVL_MSB:0];
                ADDR_SWITCHING_FREQUENCY_CTRL: double_switch_freq_nxt = reg_wdata[FSW2X_BIT];
                ADDR_WIDEBAND_ONLY_ENABLE: ultrasound_only_enable_nxt = reg_wdata[WBONLY_BIT];
                ADDR_OUTPUT_SLEW_CTRL_ONE: begin
                    fet_turnoff_slew_enable_nxt = reg_wdata[TOFF_SLEW_BIT];
                    battery_highside_slew_nxt = reg_wdata[HS_SLEW_MSB:0];
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_DG_SIGNAL_DELAY: reg_rdata_nxt = {2'h0, dg_sample_delay_r};
                ADDR_AMP_OPERATING_MODE: reg_rdata_nxt = {6'h00, amp_supply_mode_r};
                ADDR_LOW_BATTERY_LEVEL: reg_rdata_nxt = {5'h00, low_battery_force_level_r};
                ADDR_SWITCHING_FREQUENCY_CTRL: reg_rdata_nxt = {5'h00, double_switch_freq, 2'h0};
                ADDR_WIDEBAND_ONLY_ENABLE: reg_rdata_nxt = {7'h00, ultrasound_only_enable};
                ADDR_OUTPUT_SLEW_CTRL_ONE:
                    reg_rdata_nxt = {fet_turnoff_slew_enable, 3'h0, battery_highside_slew};
                default: reg_rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dg_sample_delay_r <= RST_DELAY;
            amp_supply_mode_r <= RST_MODE;
            low_battery_force_level_r <= RST_LVL;
            double_switch_freq <= RST_FSW2X;
            ultrasound_only_enable <= RST_WBONLY;
            fet_turnoff_slew_enable <= RST_TOFF_SLEW;
            battery_highside_slew <= RST_HS_SLEW;
            reg_rdata <= 8'h00;
            reg_ack <= 1'b0;
        end else begin
            dg_sample_delay_r <= dg_sample_delay_nxt;
            amp_supply_mode_r <= amp_supply_mode_nxt;
            low_battery_force_level_r <= low_battery_force_level_nxt;
            double_switch_freq <= double_switch_freq_nxt;
            ultrasound_only_enable <= ultrasound_only_enable_nxt;
            fet_turnoff_slew_enable <= fet_turnoff_slew_enable_nxt;
            battery_highside_slew <= battery_highside_slew_nxt;
            reg_rdata <= reg_rdata_nxt;
            reg_ack <= reg_ack_nxt;
        end
    end

    // ------------------------------------------------------------
    // Synchronisers for analog-side status inputs
    // ------------------------------------------------------------
    logic [7:0] vbat_s1_r, vbat_s2_r;
    logic peak_s1_r, peak_s2_r;
    logic [3:0] hold_s1_r, hold_s2_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            vbat_s1_r <= 8'h00;
            vbat_s2_r <= 8'h00;
            peak_s1_r <= 1'b0;
            peak_s2_r <= 1'b0;
            hold_s1_r <= 4'h0;
            hold_s2_r <= 4'h0;
        end else begin
            vbat_s1_r <= vbat_dv;
            vbat_s2_r <= vbat_s1_r;
            peak_s1_r <= peak_below_thresh;
            peak_s2_r <= peak_s1_r;
            hold_s1_r <= rail_switch_hold_time;
            hold_s2_r <= hold_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Rail selection
    // ------------------------------------------------------------
    logic [9:0] tick_cnt_r, tick_cnt_nxt;
    logic [14:0] hold_cnt_r, hold_cnt_nxt;
    logic hold_met, battery_low, rail_nxt, dg_active_nxt;
    logic [2:0] lvl_code;

    // Reserved level codes clamp to the top threshold
    always_comb begin
        lvl_code = (low_battery_force_level_r > LVL_MAX) ? LVL_MAX : low_battery_force_level_r;
        battery_low = vbat_s2_r < (LVL_BASE_DV + {5'h00, lvl_code});
        hold_met = hold_cnt_r >= HOLD_TICKS[hold_s2_r];
        tick_cnt_nxt = (tick_cnt_r == 10'(HOLD_TICK_CYC - 1)) ? 10'h000 : 10'(tick_cnt_r + 1'b1);
        hold_cnt_nxt = hold_cnt_r;
        if (!peak_s2_r) begin
            hold_cnt_nxt = 15'h0000;
            tick_cnt_nxt = 10'h000;
        end else if (!hold_met && tick_cnt_r == 10'(HOLD_TICK_CYC - 1)) begin
            hold_cnt_nxt = 15'(hold_cnt_r + 1'b1);
        end
        dg_active_nxt = amp_supply_mode_r == MODE_DG;
        unique case (amp_supply_mode_r)
            MODE_DG: rail_nxt = hold_met && peak_s2_r;
            MODE_HV_ONLY: rail_nxt = 1'b0;
            MODE_BAT_ONLY: rail_nxt = 1'b1;
            default: rail_nxt = 1'b0;
        endcase
        if (battery_low) begin
            rail_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_r <= 10'h000;
            hold_cnt_r <= 15'h0000;
            rail_battery_sel <= 1'b0;
            dg_active <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            rail_battery_sel <= rail_nxt;
            dg_active <= dg_active_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sample delay line
    // ------------------------------------------------------------
    cdg_fifo_if #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) dly_if ();

    cdg_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_dly (
        .mclk(mclk),
        .rst_b(rst_b),
        .f(dly_if.store)
    );

    cdg_state_type state_r, state_nxt;
    logic [SAMPLE_W-1:0] held_r, held_nxt, out_data_nxt;
    logic out_valid_nxt, in_ready_nxt;
    logic [5:0] delay_eff;
    logic [5:0] level6;

    // Effective delay: clamped, and none outside DG mode
    always_comb begin
        level6 = 6'(dly_if.level);
        if (!dg_active) begin
            delay_eff = 6'h00;
        end else if (dg_sample_delay_r > DELAY_MAX) begin
            delay_eff = DELAY_MAX;
        end else begin
            delay_eff = dg_sample_delay_r;
        end
    end

    // Once N samples are stored, each sample pops the one from N samples earlier, then is stored; with N of zero it goes straight out unstored
    always_comb begin
        state_nxt = state_r;
        held_nxt = held_r;
        out_data_nxt = audio_out_data;
        out_valid_nxt = audio_out_valid && !audio_out_ready;
        dly_if.in_valid = 1'b0;
        dly_if.in_data = held_r;
        dly_if.out_ready = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (audio_in_valid && audio_in_ready) begin
                    held_nxt = audio_in_data;
                    state_nxt = ST_TAKE;
                end else if (level6 > delay_eff) begin
                    dly_if.out_ready = 1'b1; // Drop excess after delay shrinks
                end
            end
            ST_TAKE: begin
                if (delay_eff == 6'h00) begin
                    out_data_nxt = held_r;
                    out_valid_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else if (level6 < delay_eff) begin
                    state_nxt = ST_PUSH;
                end else if (dly_if.out_valid && !out_valid_nxt) begin
                    dly_if.out_ready = 1'b1;
                    out_data_nxt = dly_if.out_data;
                    out_valid_nxt = 1'b1;
                    state_nxt = ST_PUSH;
                end
            end
            ST_PUSH: begin
                dly_if.in_valid = 1'b1;
                if (dly_if.in_ready) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
        in_ready_nxt = (state_nxt == ST_IDLE) && !out_valid_nxt;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            held_r <= '0;
            audio_out_data <= '0;
            audio_out_valid <= 1'b0;
            audio_in_ready <= 1'b0;
        end else begin
            state_r <= state_nxt;
            held_r <= held_nxt;
            audio_out_data <= out_data_nxt;
            audio_out_valid <= out_valid_nxt;
            audio_in_ready <= in_ready_nxt;
        end
    end
endmodule : cdg_supply_edge_cfg

// *** common/cdg_pkg.sv ***
package cdg_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_DG_SIGNAL_DELAY = 16'h2097;
    localparam logic [15:0] ADDR_AMP_OPERATING_MODE = 16'h2098;
    localparam logic [15:0] ADDR_LOW_BATTERY_LEVEL = 16'h2099;
    localparam logic [15:0] ADDR_SWITCHING_FREQUENCY_CTRL = 16'h209A;
    localparam logic [15:0] ADDR_WIDEBAND_ONLY_ENABLE = 16'h209B;
    localparam logic [15:0] ADDR_OUTPUT_SLEW_CTRL_ONE = 16'h209C;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int DELAY_MSB = 5;
    localparam int MODE_MSB = 1;
    localparam int LVL_MSB = 2;
    localparam int FSW2X_BIT = 2;
    localparam int WBONLY_BIT = 0;
    localparam int TOFF_SLEW_BIT = 7;
    localparam int HS_SLEW_MSB = 3;
    localparam logic [5:0] RST_DELAY = 6'h00;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [2:0] RST_LVL = 3'h3;
    localparam logic RST_FSW2X = 1'b0;
    localparam logic RST_WBONLY = 1'b0;
    localparam logic RST_TOFF_SLEW = 1'b0;
    localparam logic [3:0] RST_HS_SLEW = 4'h3;

    // ------------------------------------------------------------
    // Codes and limits
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_DG = 2'h0;
    localparam logic [1:0] MODE_HV_ONLY = 2'h1;
    localparam logic [1:0] MODE_BAT_ONLY = 2'h2;
    localparam logic [5:0] DELAY_MAX = 6'h20;
    localparam logic [2:0] LVL_MAX = 3'h5;
    localparam logic [7:0] LVL_BASE_DV = 8'h19;
    localparam int SAMPLE_W = 24;
    localparam int FIFO_DEPTH = 32;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int HOLD_TICK_NS = 50000;
    localparam int HOLD_TICK_CYC = HOLD_TICK_NS / CLK_PERIOD_NS;
    // Hold times in 50 us ticks: 0.15ms up to 1.0s
    localparam logic [14:0] HOLD_TICKS [16] = '{
        15'h0003, 15'h0005, 15'h000A, 15'h0014, 15'h0032, 15'h0064, 15'h00C8, 15'h0190,
        15'h0258, 15'h0320, 15'h03E8, 15'h09C4, 15'h1388, 15'h2710, 15'h3A98, 15'h4E20};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TAKE = 3'b010,
        ST_PUSH = 3'b100
    } cdg_state_type;
endpackage : cdg_pkg

// *** common/cdg_fifo_if.sv ***
`timescale 1ns/10ps
interface cdg_fifo_if #(parameter int WIDTH = 24, parameter int DEPTH = 32);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [$clog2(DEPTH+1)-1:0] level;
    modport filler (output in_valid, output in_data, input in_ready,
                    input out_valid, input out_data, output out_ready, input level);
    modport store (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready, output level);
endinterface : cdg_fifo_if

// *** hw/cdg_fifo.sv ***
`timescale 1ns/10ps
module cdg_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst_b,
    cdg_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [LW-1:0] cnt_r, cnt_nxt;
    logic [WIDTH-1:0] head_r;
    logic head_valid_r, head_valid_nxt;
    logic push, load;

    // --------------------------------------------------------
    // Handshakes; level counts the array plus the head register
    // --------------------------------------------------------
    assign f.in_ready = (cnt_r != LW'(DEPTH)) || load;
    assign push = f.in_valid && f.in_ready;
    assign load = (cnt_r != '0) && (!head_valid_r || f.out_ready);
    assign f.out_valid = head_valid_r;
    assign f.out_data = head_r;
    assign f.level = LW'(cnt_r + LW'(head_valid_r));

    // Next pointers and counts
    always_comb begin
        wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
        rd_ptr_nxt = load ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
        cnt_nxt = LW'(cnt_r + LW'(push) - LW'(load));
        head_valid_nxt = load || (head_valid_r && !f.out_ready);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            head_valid_r <= 1'b0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
            head_valid_r <= head_valid_nxt;
        end
    end

    // Storage array with registered read data
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_r] <= f.in_data;
        end
        if (load) begin
            head_r <= mem[rd_ptr_r];
        end
    end
endmodule : cdg_fifo

// *** verification/cdg_audio_sink.sv ***
`timescale 1ns/10ps
module cdg_audio_sink (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [cdg_pkg::SAMPLE_W-1:0] data,
    input wire logic valid,
    input wire logic stall,
    output logic ready
);
    import cdg_pkg::*;
    logic [SAMPLE_W-1:0] got_q [$];
    logic [1:0] phase;
    initial begin
        ready = 1'b0;
        phase = 2'h0;
    end
    // Collect accepted samples, then pick ready just after the edge
    always @(posedge mclk) begin
        if (rst_b && valid && ready) begin
            got_q.push_back(data);
        end
        phase <= phase + 2'h1;
        #2;
        ready = rst_b && (!stall || phase == 2'h0); // Stalls three cycles of four
    end
endmodule : cdg_audio_sink

// *** verification/cdg_supply_edge_cfg_asserts.sv ***
`timescale 1ns/10ps
module cdg_supply_edge_cfg_asserts (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic [cdg_pkg::SAMPLE_W-1:0] audio_out_data,
    input wire logic audio_out_valid,
    input wire logic audio_out_ready,
    input wire logic [7:0] vbat_dv,
    input wire logic rail_battery_sel,
    input wire logic dg_active,
    input wire logic double_switch_freq,
    input wire logic ultrasound_only_enable,
    input wire logic fet_turnoff_slew_enable,
    input wire logic [3:0] battery_highside_slew
);
    import cdg_pkg::*;
    logic [1:0] mode_r, mode_nxt;
    logic [2:0] lvl_r, lvl_nxt;
    logic [7:0] lim;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // Shadow of mode and level fields
    // ------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        lvl_nxt = lvl_r;
        if (reg_wr && reg_addr == ADDR_AMP_OPERATING_MODE) begin
            mode_nxt = reg_wdata[1:0];
        end
        if (reg_wr && reg_addr == ADDR_LOW_BATTERY_LEVEL) begin
            lvl_nxt = reg_wdata[2:0];
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= RST_MODE;
            lvl_r <= RST_LVL;
        end else begin
            mode_r <= mode_nxt;
            lvl_r <= lvl_nxt;
        end
    end
    // Reserved codes act as the top level
    assign lim = LVL_BASE_DV + ((lvl_r > LVL_MAX) ? 8'(LVL_MAX) : 8'(lvl_r));
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_ack_access: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("no ack after access");
    a_ack_idle: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
        else $error("ack without access");
    a_fsw_write: assert property (
        (reg_wr && reg_addr == ADDR_SWITCHING_FREQUENCY_CTRL) ##1 !reg_wr
        |=> double_switch_freq == $past(reg_wdata[FSW2X_BIT], 2))
        else $error("switch frequency bit wrong");
    a_wb_write: assert property (
        (reg_wr && reg_addr == ADDR_WIDEBAND_ONLY_ENABLE) ##1 !reg_wr
        |=> ultrasound_only_enable == $past(reg_wdata[WBONLY_BIT], 2))
        else $error("ultrasound bit wrong");
    a_slew_write: assert property (
        (reg_wr && reg_addr == ADDR_OUTPUT_SLEW_CTRL_ONE) ##1 !reg_wr
        |=> {fet_turnoff_slew_enable, 3'h0, battery_highside_slew} == ($past(reg_wdata, 2) & 8'h8F))
        else $error("slew fields wrong");
    a_mode_dg: assert property (
        (reg_wr && reg_addr == ADDR_AMP_OPERATING_MODE) ##1 !reg_wr
        |=> dg_active == ($past(reg_wdata[1:0], 2) == MODE_DG))
        else $error("dg flag wrong");
    a_hv_mode: assert property ((mode_r == MODE_HV_ONLY)[*4] |-> !rail_battery_sel)
        else $error("battery rail in high voltage mode");
    a_bat_mode: assert property (
        (mode_r == MODE_BAT_ONLY && vbat_dv >= lim)[*6] |-> rail_battery_sel)
        else $error("battery rail not used");
    a_low_force: assert property ((vbat_dv < lim)[*6] |-> !rail_battery_sel)
        else $error("low battery not forced");
    a_out_stands: assert property (
        audio_out_valid && !audio_out_ready |=> audio_out_valid && $stable(audio_out_data))
        else $error("output dropped before ready");
    c_mode_wr: cover property (reg_wr && reg_addr == ADDR_AMP_OPERATING_MODE);
    c_out_take: cover property (audio_out_valid && audio_out_ready);
    c_rail_bat: cover property ($rose(rail_battery_sel));
endmodule : cdg_supply_edge_cfg_asserts

bind cdg_supply_edge_cfg cdg_supply_edge_cfg_asserts cdg_supply_edge_cfg_asserts_i (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_ack(reg_ack), .audio_out_data(audio_out_data),
    .audio_out_valid(audio_out_valid), .audio_out_ready(audio_out_ready),
    .vbat_dv(vbat_dv), .rail_battery_sel(rail_battery_sel), .dg_active(dg_active),
    .double_switch_freq(double_switch_freq), .ultrasound_only_enable(ultrasound_only_enable),
    .fet_turnoff_slew_enable(fet_turnoff_slew_enable),
    .battery_highside_slew(battery_highside_slew));

// *** verification/cdg_supply_edge_cfg_bench.sv ***
`timescale 1ns/10ps
module cdg_supply_edge_cfg_bench;
    import cdg_pkg::*;
    logic mclk, rst_b, reg_wr, reg_rd, reg_ack, in_valid, in_ready, out_valid, out_ready;
    logic peak_below, rail_bat, dg_act, fsw2x, us_only, toff_slew, stall;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, vbat_dv;
    logic [3:0] hold_code, hs_slew;
    logic [SAMPLE_W-1:0] in_data, out_data;
    int miscompares, tests_run;
    logic [7:0] rst_t [6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h03};
    logic [7:0] ff_t [6] = '{8'h3F, 8'h03, 8'h07, 8'h04, 8'h01, 8'h8F};
    logic [2:0] lvl_t [4] = '{3'h3, 3'h0, 3'h7, 3'h5};
    logic [7:0] vb_t [4] = '{8'h1B, 8'h1B, 8'h1D, 8'h1E};
    logic vexp_t [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    cdg_supply_edge_cfg cdg_supply_edge_cfg_i (.mclk(mclk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .audio_in_data(in_data),
        .audio_in_valid(in_valid), .audio_in_ready(in_ready), .audio_out_data(out_data),
        .audio_out_valid(out_valid), .audio_out_ready(out_ready), .vbat_dv(vbat_dv),
        .peak_below_thresh(peak_below), .rail_switch_hold_time(hold_code),
        .rail_battery_sel(rail_bat), .dg_active(dg_act), .double_switch_freq(fsw2x),
        .ultrasound_only_enable(us_only), .fet_turnoff_slew_enable(toff_slew),
        .battery_highside_slew(hs_slew));
    cdg_audio_sink cdg_audio_sink_i (.mclk(mclk), .rst_b(rst_b), .data(out_data),
        .valid(out_valid), .stall(stall), .ready(out_ready));

    // ------------------------------------------------------------
    // Compare, access and stream tasks
    // ------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : check8
    task automatic check24(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t sample %h exp %h", $time, got, exp);
        end
    endtask : check24
    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #2;
        reg_wr = 1'b0;
        check8(8'(reg_ack), 8'h01);
    endtask : reg_write
    task automatic reg_read(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #2;
        reg_rd = 1'b0;
        check8(8'(reg_ack), 8'h01);
        check8(reg_rdata, exp);
    endtask : reg_read
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : wait_cyc
    task automatic send(input logic [23:0] s);
        @(posedge mclk);
        #2;
        in_data = s;
        in_valid = 1'b1;
        for (int n = 0; n < 100 && !in_ready; n++) begin
            wait_cyc(1);
        end
        wait_cyc(1);
        in_valid = 1'b0;
        in_data = ~s;
    endtask : send
    // Fresh run: drain through mode 1, set delay and mode, compare output order
    task automatic audio_run(input logic [7:0] m, input logic [7:0] c, input int n, input int k);
        reg_write(ADDR_AMP_OPERATING_MODE, 8'(MODE_HV_ONLY));
        wait_cyc(40); // Stored samples leave one per cycle
        reg_write(ADDR_DG_SIGNAL_DELAY, c);
        reg_write(ADDR_AMP_OPERATING_MODE, m);
        cdg_audio_sink_i.got_q.delete();
        for (int i = 0; i < n; i++) begin
            send(24'hA50000 + 24'(i));
        end
        wait_cyc(30);
        check8(8'(cdg_audio_sink_i.got_q.size()), 8'(n - k));
        foreach (cdg_audio_sink_i.got_q[i]) begin
            check24(cdg_audio_sink_i.got_q[i], 24'hA50000 + 24'(i));
        end
    endtask : audio_run
    task finish_test;
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        finish_test;
    end
    initial begin
        {rst_b, reg_wr, reg_rd, in_valid, peak_below, stall} = 6'h00;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        in_data = 24'h000000;
        vbat_dv = 8'h28;
        hold_code = 4'h0;
        miscompares = 0;
        tests_run = 0;
        repeat (20) @(posedge mclk);
        #2;
        rst_b = 1'b1;
        for (int i = 0; i < 6; i++) begin
            reg_read(ADDR_DG_SIGNAL_DELAY + 16'(i), rst_t[i]);
        end
        reg_write(16'h2096, 8'hFF);
        reg_read(16'h2096, 8'h00);
        reg_read(16'h209D, 8'h00);
        for (int i = 0; i < 6; i++) begin
            reg_write(ADDR_DG_SIGNAL_DELAY + 16'(i), 8'hFF);
        end
        for (int i = 0; i < 6; i++) begin
            reg_read(ADDR_DG_SIGNAL_DELAY + 16'(i), ff_t[i]);
        end
        check8({4'h0, fsw2x, us_only, toff_slew, dg_act}, 8'h0E);
        check8(8'(hs_slew), 8'h0F);
        for (int i = 0; i < 3; i++) begin
            reg_write(ADDR_SWITCHING_FREQUENCY_CTRL + 16'(i), 8'h00);
        end
        check8({4'h0, fsw2x, us_only, toff_slew, 1'b0}, 8'h00);
        check8(8'(hs_slew), 8'h00);
        audio_run(8'(MODE_DG), 8'h03, 6, 3);
        stall = 1'b1;
        audio_run(8'(MODE_DG), 8'h00, 4, 0);
        stall = 1'b0;
        audio_run(8'(MODE_DG), 8'h20, 33, 32);
        audio_run(8'(MODE_DG), 8'h3F, 34, 32);
        audio_run(8'(MODE_BAT_ONLY), 8'h05, 4, 0);
        wait_cyc(10);
        check8(8'(rail_bat), 8'h01);
        for (int i = 0; i < 4; i++) begin
            reg_write(ADDR_LOW_BATTERY_LEVEL, 8'(lvl_t[i]));
            vbat_dv = vb_t[i];
            wait_cyc(10);
            check8(8'(rail_bat), 8'(vexp_t[i]));
        end
        vbat_dv = 8'h28;
        reg_write(ADDR_AMP_OPERATING_MODE, 8'(MODE_HV_ONLY));
        wait_cyc(10);
        check8({6'h00, dg_act, rail_bat}, 8'h00);
        reg_write(ADDR_AMP_OPERATING_MODE, 8'h03);
        wait_cyc(10);
        check8({6'h00, dg_act, rail_bat}, 8'h00);
        reg_write(ADDR_AMP_OPERATING_MODE, 8'(MODE_DG));
        peak_below = 1'b1;
        wait_cyc(1500);
        check8({6'h00, dg_act, rail_bat}, 8'h02);
        wait_cyc(1700);
        check8(8'(rail_bat), 8'h01);
        peak_below = 1'b0;
        wait_cyc(10);
        check8(8'(rail_bat), 8'h00);
        finish_test;
    end
endmodule : cdg_supply_edge_cfg_bench
